// file: verilog/wstm_pkg.sv
// Constants, register map and phase type for the weld sequence tail monitor.
// Assumes a single 125 MHz control clock; all phase times are in milliseconds.
package wstm_pkg;
	// Millisecond tick derived from the control clock
	localparam int CLK_KHZ  = 125000;
	localparam int TICK_MS  = 1;
	localparam int TICK_CYC = CLK_KHZ * TICK_MS;

	// Register byte offsets (32-bit words)
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_TIME_A   = 8'h04;
	localparam logic [7:0] REG_TIME_B   = 8'h08;
	localparam logic [7:0] REG_DOWN     = 8'h0C;
	localparam logic [7:0] REG_POST_AMP = 8'h10;
	localparam logic [7:0] REG_DELAY    = 8'h14;
	localparam logic [7:0] REG_INSP_EN  = 8'h18;
	localparam logic [7:0] REG_PROG     = 8'h1C;
	localparam logic [7:0] REG_FORCE    = 8'h20;
	localparam logic [7:0] REG_STATUS   = 8'h24;
	localparam logic [1:0] SLOT_REGION  = 2'h1;
	localparam logic [1:0] SLOT_NOM     = 2'h0;
	localparam logic [1:0] SLOT_TOL     = 2'h1;
	localparam logic [1:0] SLOT_WIN     = 2'h2;

	// Field positions
	localparam int CTRL_SERIES   = 0;
	localparam int FORCE_IDX_LSB = 8;
	localparam int STAT_FAULT    = 3;
	localparam int STAT_EMPTY    = 4;
	localparam int STAT_CALC     = 5;
	localparam int STAT_INSP_LSB = 6;
	localparam int STAT_MS_LSB   = 16;

	// Sizes
	localparam int DW       = 16;
	localparam int NUM_PROG = 4;
	localparam int INSP_MAX = 3;

	// Force scaling: percent in, millivolts out
	localparam logic [6:0] FORCE_MAX_PCT  = 7'h63;
	localparam int         FORCE_FULL_PCT = 99;
	localparam int         FORCE_FULL_MV  = 9960;

	// Reset values
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	localparam logic [15:0] RST_HALF    = 16'h0000;
	localparam logic [7:0]  RST_INSP_EN = 8'h00;
	localparam logic [6:0]  RST_FORCE   = 7'h00;

	typedef enum logic [2:0] {
		PH_IDLE, PH_DOWN, PH_RECOOL, PH_POST, PH_HOLD, PH_FAULT, PH_OPEN, PH_SQZ
	} wstm_phase_e;
endpackage : wstm_pkg

// file: verilog/wstm_insp.sv
// One inspector slot: tolerance check and deviation window on a sample stream.
// Assumes samples arrive only while the measurement window is open.
`timescale 1ns/1ps
`default_nettype none
module wstm_insp (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        clear,
	input  wire logic        enable,
	input  wire logic        smp_valid,
	input  wire logic [15:0] smp,
	input  wire logic [15:0] nominal,
	input  wire logic [15:0] tol_pos,
	input  wire logic [15:0] tol_neg,
	input  wire logic [15:0] win,
	input  wire logic        close,
	output logic             done,
	output logic             fault,
	output logic             seen
);
	logic [15:0] acc;

	// Limits; a lower limit below zero can never be undershot
	wire [16:0] upper = {1'b0, nominal} + {1'b0, tol_pos};
	wire [16:0] lower = {1'b0, nominal} - {1'b0, tol_neg};
	wire        take  = enable && smp_valid;
	wire        above = {1'b0, smp} > upper;
	wire        below = !lower[16] && (smp < lower[15:0]);
	wire        dev   = take && (above || below);

	// Deviations add, good samples drain; a lone outlier trips only when win is zero
	wire [15:0] inc      = (acc == 16'hFFFF) ? acc : acc + 16'h0001;
	wire [15:0] dec      = (acc == 16'h0000) ? acc : acc - 16'h0001;
	wire [15:0] next_acc = dev ? inc : (take ? dec : acc);
	wire        trip     = dev && (next_acc > win);

	// Clear at weld start; a trip in the same cycle still wins
	always_ff @(posedge core_clk) begin
		if (srst) begin
			acc   <= wstm_pkg::RST_HALF;
			done  <= 1'b1;
			fault <= 1'b0;
			seen  <= 1'b0;
		end else begin
			acc   <= clear ? wstm_pkg::RST_HALF : next_acc;
			done  <= close || (done && !clear);
			fault <= trip || (fault && !clear);
			seen  <= take || (seen && !clear);
		end
	end
endmodule : wstm_insp
`default_nettype wire

// file: verilog/wstm_top.sv
// Tail of a resistance-weld sequence: decrease, recool, post-heat, hold, open.
// Also force output scaling, measurement window and three inspector slots.
// Assumes all process inputs are synchronous to core_clk; Avalon-MM slave.
`timescale 1ns/1ps
`default_nettype none
// Function
// - After main current, wait a programmed current-free recool with gun closed.
// - Post-heat current starts from the amplitude where the decrease ended.
// - Drive the configured post-heat current for the programmed post-heat time.
// - Hold begins right after the last current phase, main or post-heat.
// - During hold keep gun closed for the programmed time, no current.
// - Extend hold until monitoring and inspector calculations are complete.
// - Good weld: at hold end open gun, pulse end-of-sequence, release interlock.
// - Faulty weld: no end-of-sequence, prolong hold, gun closed, raise fault.
// - Operator acknowledge ends prolonged hold, opens gun, signals end-of-sequence.
// - Open time runs only in series spot mode, starting at hold end.
// - Open time drops solenoid; on expiry close gun, start next squeeze.
// - Start withdrawn during open time ends it and the series at once.
// - Force percent maps linearly to valve voltage, 99 percent to 9.96 V.
// - Force value goes to valve and field bus at the same time.
// - Force of a program takes effect as soon as it is selected.
// - At most three inspectors may be active together.
// - After each weld every active inspector flags deviations from nominal.
// - Measurement window opens at first current plus programmed start delay.
// - Measurement window closes when current time ends.
// - Start delay longer than current time gives an empty window, no measurement.
// - Separate positive and negative tolerances; exceeding either raises a message.
// - Deviation window suppresses isolated outliers, flags accumulated deviations.
// - Decrease ramps from main current to zero or to post-heat current.
module wstm_top #(
	parameter int TICK_CYC = wstm_pkg::TICK_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        main_end,
	input  wire logic [15:0] main_amp,
	input  wire logic        cur_on,
	input  wire logic        start_in,
	input  wire logic        fault_ack,
	input  wire logic        calc_busy,
	input  wire logic        smp_valid,
	input  wire logic [47:0] smp_data,
	output logic             gun_close,
	output logic             weld_on,
	output logic      [15:0] weld_amp,
	output logic             end_of_seq,
	output logic             start_interlock,
	output logic             next_squeeze,
	output logic             series_end,
	output logic             fault_acknowledge_message,
	output logic             meas_open,
	output logic             meas_empty,
	output logic      [15:0] valve_mv,
	output logic      [6:0]  fbus_force,
	output logic      [2:0]  insp_fault
);
	localparam int S    = wstm_pkg::INSP_MAX;
	localparam int DW   = wstm_pkg::DW;
	localparam int DIVW = $clog2(TICK_CYC + 1);

	wstm_pkg::wstm_phase_e phase, next_phase, after_main, after_cur, fin_next;
	logic [DIVW-1:0] div;
	logic [15:0] ms_left, load_ms, amp, next_amp, dly_left;
	logic [31:0] time_a, time_b, down_cfg, rd_mux;
	logic [15:0] post_amp, meas_delay;
	logic [7:0]  insp_en;
	logic [1:0]  prog;
	logic        series, ack_q, cur_q, armed;
	logic [6:0]  force_tab [wstm_pkg::NUM_PROG];
	logic [15:0] nom [S];
	logic [15:0] tolp [S];
	logic [15:0] toln [S];
	logic [15:0] win [S];
	logic [S-1:0] slot_act, slot_done, slot_fault, slot_seen;

	function automatic logic [3:0] ones8(input logic [7:0] v);
		ones8 = 4'h0;
		for (int i = 0; i < 8; i++) begin
			ones8 = ones8 + {3'h0, v[i]};
		end
	endfunction : ones8

	// Step toward a target; a zero step jumps straight to it
	function automatic logic [15:0] toward(input logic [15:0] a, input logic [15:0] t, input logic [15:0] s);
		logic [16:0] dn;
		logic [16:0] up;
		dn = {1'b0, a} - {1'b0, s};
		up = {1'b0, a} + {1'b0, s};
		if (s == 16'h0000)
			toward = t;
		else if (a > t)
			toward = (dn[16] || dn[15:0] < t) ? t : dn[15:0];
		else
			toward = (up > {1'b0, t}) ? t : up[15:0];
	endfunction : toward

	function automatic logic [15:0] pct_to_mv(input logic [6:0] p);
		logic [20:0] prod;
		prod = 21'(p) * 21'(wstm_pkg::FORCE_FULL_MV);
		pct_to_mv = 16'(prod / 21'(wstm_pkg::FORCE_FULL_PCT));
	endfunction : pct_to_mv

	// Configuration fields
	wire [15:0] recool_ms = time_a[15:0];
	wire [15:0] post_ms   = time_a[31:16];
	wire [15:0] hold_ms   = time_b[15:0];
	wire [15:0] open_ms   = time_b[31:16];
	wire [15:0] down_ms   = down_cfg[15:0];
	wire [15:0] down_step = down_cfg[31:16];
	wire        dec_cfg   = down_ms != 16'h0000;
	wire        post_cfg  = post_ms != 16'h0000;
	wire [15:0] dec_target = post_cfg ? post_amp : wstm_pkg::RST_HALF;

	// Bus decode; every access waits exactly one cycle
	wire        req      = avs_read || avs_write;
	wire        wr       = avs_write && ack_q;
	wire [7:0]  addr     = {avs_address[7:2], 2'b00};
	wire        slot_rgn = addr[7:6] == wstm_pkg::SLOT_REGION;
	wire [1:0]  slot_idx = addr[5:4];
	wire [1:0]  slot_fld = addr[3:2];
	wire        slot_ok  = slot_rgn && (32'(slot_idx) < S) && (slot_fld != 2'h3);
	wire [6:0]  pct_in   = (avs_writedata[6:0] > wstm_pkg::FORCE_MAX_PCT) ? wstm_pkg::FORCE_MAX_PCT
		: avs_writedata[6:0];
	wire [1:0]  f_idx    = avs_writedata[wstm_pkg::FORCE_IDX_LSB +: 2];
	wire        insp_ok  = ones8(avs_writedata[7:0]) <= 4'(S);
	assign avs_waitrequest = req && !ack_q;

	// Sequencing terms
	wire tick      = div == DIVW'(TICK_CYC - 1);
	wire expired   = ms_left == 16'h0000;
	wire phase_chg = next_phase != phase;
	wire cur_rise  = cur_on && !cur_q;
	wire cur_fall  = !cur_on && cur_q;
	wire calc_done = (&(slot_done | ~slot_act)) && !calc_busy;
	wire any_fault = |(slot_fault & slot_act);
	wire next_cur  = (next_phase == wstm_pkg::PH_DOWN) || (next_phase == wstm_pkg::PH_POST);
	assign after_cur  = post_cfg ? wstm_pkg::PH_RECOOL : wstm_pkg::PH_HOLD;
	assign after_main = dec_cfg ? wstm_pkg::PH_DOWN : after_cur;
	assign fin_next   = (series && start_in) ? wstm_pkg::PH_OPEN : wstm_pkg::PH_IDLE;

	// Phase transitions
	always_comb begin
		next_phase = phase;
		unique case (phase)
			wstm_pkg::PH_IDLE, wstm_pkg::PH_SQZ: begin
				if (main_end)
					next_phase = after_main;
				else if (phase == wstm_pkg::PH_SQZ && !start_in)
					next_phase = wstm_pkg::PH_IDLE;
			end
			wstm_pkg::PH_DOWN: begin
				if (expired)
					next_phase = after_cur;
			end
			wstm_pkg::PH_RECOOL: begin
				if (expired)
					next_phase = wstm_pkg::PH_POST;
			end
			wstm_pkg::PH_POST: begin
				if (expired)
					next_phase = wstm_pkg::PH_HOLD;
			end
			wstm_pkg::PH_HOLD: begin
				if (expired && calc_done)
					next_phase = any_fault ? wstm_pkg::PH_FAULT : fin_next;
			end
			wstm_pkg::PH_FAULT: begin
				if (fault_ack)
					next_phase = fin_next;
			end
			wstm_pkg::PH_OPEN: begin
				if (!start_in)
					next_phase = wstm_pkg::PH_IDLE;
				else if (expired)
					next_phase = wstm_pkg::PH_SQZ;
			end
		endcase
	end

	// Duration loaded on entry to each timed phase
	always_comb begin
		unique case (next_phase)
			wstm_pkg::PH_DOWN:   load_ms = down_ms;
			wstm_pkg::PH_RECOOL: load_ms = recool_ms;
			wstm_pkg::PH_POST:   load_ms = post_ms;
			wstm_pkg::PH_HOLD:   load_ms = hold_ms;
			wstm_pkg::PH_OPEN:   load_ms = open_ms;
			wstm_pkg::PH_IDLE, wstm_pkg::PH_FAULT, wstm_pkg::PH_SQZ: load_ms = wstm_pkg::RST_HALF;
		endcase
	end

	// Amplitude: ramp during decrease, settle toward post-heat level
	always_comb begin
		next_amp = amp;
		if (phase_chg && next_phase == wstm_pkg::PH_DOWN)
			next_amp = main_amp;
		else if (phase_chg && next_phase == wstm_pkg::PH_POST && !dec_cfg)
			next_amp = post_amp;
		else if (tick && phase == wstm_pkg::PH_DOWN)
			next_amp = toward(amp, dec_target, down_step);
		else if (tick && phase == wstm_pkg::PH_POST)
			next_amp = toward(amp, post_amp, down_step);
	end

	// Millisecond divider restarts with each phase so a phase lasts whole ticks
	always_ff @(posedge core_clk) begin
		if (srst || phase_chg || cur_rise || tick)
			div <= '0;
		else
			div <= div + 1'b1;
	end

	// Phase register and its timer
	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase   <= wstm_pkg::PH_IDLE;
			ms_left <= wstm_pkg::RST_HALF;
			amp     <= wstm_pkg::RST_HALF;
		end else begin
			phase <= next_phase;
			amp   <= next_amp;
			if (phase_chg)
				ms_left <= load_ms;
			else if (tick && !expired)
				ms_left <= ms_left - 16'h0001;
		end
	end

	// Gun, current and sequence outputs, registered from the next phase
	wire fin_edge = (phase == wstm_pkg::PH_HOLD || phase == wstm_pkg::PH_FAULT)
		&& (next_phase == wstm_pkg::PH_OPEN || next_phase == wstm_pkg::PH_IDLE);
	wire closed_nx = !(next_phase == wstm_pkg::PH_IDLE || next_phase == wstm_pkg::PH_OPEN);
	wire lock_nx = closed_nx && next_phase != wstm_pkg::PH_SQZ;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			gun_close       <= 1'b0;
			weld_on         <= 1'b0;
			weld_amp        <= wstm_pkg::RST_HALF;
			end_of_seq      <= 1'b0;
			start_interlock <= 1'b0;
			next_squeeze    <= 1'b0;
			series_end      <= 1'b0;
			fault_acknowledge_message <= 1'b0;
		end else begin
			gun_close       <= closed_nx;
			weld_on         <= next_cur;
			weld_amp        <= next_cur ? next_amp : wstm_pkg::RST_HALF;
			end_of_seq      <= fin_edge;
			start_interlock <= lock_nx;
			next_squeeze    <= phase == wstm_pkg::PH_OPEN && next_phase == wstm_pkg::PH_SQZ;
			series_end      <= (phase == wstm_pkg::PH_OPEN || phase == wstm_pkg::PH_SQZ)
				&& next_phase == wstm_pkg::PH_IDLE;
			fault_acknowledge_message <= next_phase == wstm_pkg::PH_FAULT;
		end
	end

	// Measurement window; an upstream current time is one cur_on level
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cur_q      <= 1'b0;
			armed      <= 1'b0;
			dly_left   <= wstm_pkg::RST_HALF;
			meas_open  <= 1'b0;
			meas_empty <= 1'b0;
		end else begin
			cur_q <= cur_on;
			if (cur_rise) begin
				armed      <= 1'b1;
				dly_left   <= meas_delay;
				meas_empty <= 1'b0;
				meas_open  <= 1'b0;
			end else if (cur_fall) begin
				armed      <= 1'b0;
				meas_open  <= 1'b0;
				meas_empty <= !meas_open;
			end else if (armed) begin
				if (dly_left == 16'h0000)
					meas_open <= 1'b1;
				else if (tick)
					dly_left <= dly_left - 16'h0001;
			end
		end
	end

	// Force output; table lookup follows the selected program every cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			valve_mv   <= wstm_pkg::RST_HALF;
			fbus_force <= wstm_pkg::RST_FORCE;
			insp_fault <= '0;
		end else begin
			valve_mv   <= pct_to_mv(force_tab[prog]);
			fbus_force <= force_tab[prog];
			insp_fault <= slot_fault & slot_act;
		end
	end

	// Inspector slots; the first N slots follow the count of enabled inspectors
	for (genvar k = 0; k < S; k++) begin : g_slot
		wire wr_slot = wr && slot_ok && (32'(slot_idx) == k);
		assign slot_act[k] = ones8(insp_en) > 4'(k);
		always_ff @(posedge core_clk) begin
			if (srst) begin
				nom[k]  <= wstm_pkg::RST_HALF;
				tolp[k] <= wstm_pkg::RST_HALF;
				toln[k] <= wstm_pkg::RST_HALF;
				win[k]  <= wstm_pkg::RST_HALF;
			end else if (wr_slot) begin
				if (slot_fld == wstm_pkg::SLOT_NOM)
					nom[k] <= avs_writedata[15:0];
				if (slot_fld == wstm_pkg::SLOT_TOL) begin
					tolp[k] <= avs_writedata[15:0];
					toln[k] <= avs_writedata[31:16];
				end
				if (slot_fld == wstm_pkg::SLOT_WIN)
					win[k] <= avs_writedata[15:0];
			end
		end
		wstm_insp u_insp (
			.core_clk  (core_clk),
			.srst      (srst),
			.clear     (cur_rise),
			.enable    (slot_act[k]),
			.smp_valid (smp_valid && meas_open),
			.smp       (smp_data[k*DW +: DW]),
			.nominal   (nom[k]),
			.tol_pos   (tolp[k]),
			.tol_neg   (toln[k]),
			.win       (win[k]),
			.close     (cur_fall),
			.done      (slot_done[k]),
			.fault     (slot_fault[k]),
			.seen      (slot_seen[k])
		);
	end

	// Control registers; an inspector set with too many bits is refused
	always_ff @(posedge core_clk) begin
		if (srst) begin
			series     <= 1'b0;
			time_a     <= wstm_pkg::RST_WORD;
			time_b     <= wstm_pkg::RST_WORD;
			down_cfg   <= wstm_pkg::RST_WORD;
			post_amp   <= wstm_pkg::RST_HALF;
			meas_delay <= wstm_pkg::RST_HALF;
			insp_en    <= wstm_pkg::RST_INSP_EN;
			prog       <= 2'h0;
			for (int i = 0; i < wstm_pkg::NUM_PROG; i++)
				force_tab[i] <= wstm_pkg::RST_FORCE;
		end else if (wr) begin
			if (addr == wstm_pkg::REG_CTRL)
				series <= avs_writedata[wstm_pkg::CTRL_SERIES];
			if (addr == wstm_pkg::REG_TIME_A)
				time_a <= avs_writedata;
			if (addr == wstm_pkg::REG_TIME_B)
				time_b <= avs_writedata;
			if (addr == wstm_pkg::REG_DOWN)
				down_cfg <= avs_writedata;
			if (addr == wstm_pkg::REG_POST_AMP)
				post_amp <= avs_writedata[15:0];
			if (addr == wstm_pkg::REG_DELAY)
				meas_delay <= avs_writedata[15:0];
			if (addr == wstm_pkg::REG_INSP_EN && insp_ok)
				insp_en <= avs_writedata[7:0];
			if (addr == wstm_pkg::REG_PROG)
				prog <= avs_writedata[1:0];
			if (addr == wstm_pkg::REG_FORCE)
				force_tab[f_idx] <= pct_in;
		end
	end

	// Read mux; unmapped addresses read zero
	wire [31:0] status = {ms_left, 7'h00, slot_fault & slot_act, calc_done, meas_empty,
		fault_acknowledge_message, phase};
	wire [31:0] slot_rd = (slot_fld == wstm_pkg::SLOT_NOM) ? {16'h0000, nom[slot_idx]}
		: (slot_fld == wstm_pkg::SLOT_TOL) ? {toln[slot_idx], tolp[slot_idx]}
		: {16'h0000, win[slot_idx]};
	always_comb begin
		rd_mux = wstm_pkg::RST_WORD;
		if (slot_ok)
			rd_mux = slot_rd;
		else if (addr == wstm_pkg::REG_CTRL)
			rd_mux = {31'h0, series};
		else if (addr == wstm_pkg::REG_TIME_A)
			rd_mux = time_a;
		else if (addr == wstm_pkg::REG_TIME_B)
			rd_mux = time_b;
		else if (addr == wstm_pkg::REG_DOWN)
			rd_mux = down_cfg;
		else if (addr == wstm_pkg::REG_POST_AMP)
			rd_mux = {16'h0000, post_amp};
		else if (addr == wstm_pkg::REG_DELAY)
			rd_mux = {16'h0000, meas_delay};
		else if (addr == wstm_pkg::REG_INSP_EN)
			rd_mux = {24'h000000, insp_en};
		else if (addr == wstm_pkg::REG_PROG)
			rd_mux = {30'h0, prog};
		else if (addr == wstm_pkg::REG_FORCE)
			rd_mux = {25'h0, force_tab[prog]};
		else if (addr == wstm_pkg::REG_STATUS)
			rd_mux = status;
	end

	// Read data latched in the wait cycle so it stands when waitrequest falls
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ack_q        <= 1'b0;
			avs_readdata <= wstm_pkg::RST_WORD;
		end else begin
			ack_q <= req && !ack_q;
			if (req && !ack_q)
				avs_readdata <= rd_mux;
		end
	end
endmodule : wstm_top
`default_nettype wire

// file: verif/wstm_src.sv
// Upstream model: current time, samples and main-current end pulse.
// Assumes go is a one-cycle request from the bench.
`timescale 1ns/1ps
`default_nettype none
module wstm_src (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        go,
	input  wire logic [7:0]  cur_len,
	input  wire logic [15:0] smp_val,
	output logic             main_end,
	output logic      [15:0] main_amp,
	output logic             cur_on,
	output logic             smp_valid,
	output logic      [47:0] smp_data
);
	logic [7:0] cnt;

	// Current runs cur_len cycles; main end pulses as it falls
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt      <= 8'h00;
			cur_on   <= 1'b0;
			main_end <= 1'b0;
		end else begin
			main_end <= cur_on && cnt == 8'h01;
			if (go) begin
				cnt    <= cur_len;
				cur_on <= 1'b1;
			end else if (cnt != 8'h00) begin
				cnt    <= cnt - 8'h01;
				cur_on <= cnt != 8'h01;
			end
		end
	end

	// Idle bus shows the inverse so a stale sample never looks good
	assign smp_valid = cur_on;
	assign smp_data  = cur_on ? {3{smp_val}} : {3{~smp_val}};
	assign main_amp  = 16'h0800;
endmodule : wstm_src
`default_nettype wire

// file: verif/wstm_top_props.sv
// Checker for the weld tail sequencer outputs.
// Assumes it is bound into wstm_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wstm_props #(
	parameter int TICK_CYC = 10
) (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        fault_ack,
	input wire logic        calc_busy,
	input wire logic        gun_close,
	input wire logic        weld_on,
	input wire logic [15:0] weld_amp,
	input wire logic        end_of_seq,
	input wire logic        start_interlock,
	input wire logic        next_squeeze,
	input wire logic        fault_acknowledge_message,
	input wire logic        meas_open,
	input wire logic        meas_empty,
	input wire logic [15:0] valve_mv,
	input wire logic [6:0]  fbus_force
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	no_current_a: assert property (!weld_on |-> weld_amp == 16'h0000)
		else $error("setpoint outside current phase");
	calc_hold_a: assert property (calc_busy && !fault_acknowledge_message |=> !end_of_seq)
		else $error("hold ended while calc busy");
	eos_pulse_a: assert property (end_of_seq |=> !end_of_seq [*2])
		else $error("end of sequence not a pulse");
	eos_open_a: assert property (end_of_seq |-> !gun_close && !start_interlock)
		else $error("gun or interlock held at end");
	fault_closed_a: assert property (fault_acknowledge_message |-> gun_close && !end_of_seq && !weld_on)
		else $error("faulty weld released gun");
	ack_ends_a: assert property (fault_acknowledge_message && fault_ack |=> end_of_seq)
		else $error("acknowledge did not end hold");
	squeeze_close_a: assert property (next_squeeze |-> gun_close && !$past(gun_close))
		else $error("gun not closed at next squeeze");
	force_pair_a: assert property (32'(valve_mv) == 32'(fbus_force) * 9960 / 99)
		else $error("valve and bus force disagree");
	empty_window_a: assert property (meas_empty |-> !meas_open)
		else $error("empty window shown open");

	// Main scenarios reached
	eos_c: cover property (end_of_seq);
	fault_c: cover property (fault_acknowledge_message && fault_ack);
	squeeze_c: cover property (next_squeeze);
	empty_c: cover property (meas_empty);
endmodule : wstm_props

bind wstm_top wstm_props #(.TICK_CYC(TICK_CYC)) u_props (.core_clk, .srst, .fault_ack, .calc_busy,
	.gun_close, .weld_on, .weld_amp, .end_of_seq, .start_interlock, .next_squeeze,
	.fault_acknowledge_message, .meas_open, .meas_empty, .valve_mv, .fbus_force);
`default_nettype wire

// file: verif/tb_top.sv
// Bench: Avalon-MM register setup, then weld tails run through the model.
// Assumes wstm_src stands upstream and TICK_CYC of 10 cycles per ms.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        core_clk, srst, rd, wr, wait_rq, go, start_in, fault_ack, calc_busy;
	logic        main_end, cur_on, smp_valid, gun_close, weld_on, end_of_seq, start_interlock;
	logic        next_squeeze, series_end, fault_msg, meas_open, meas_empty;
	logic [7:0]  addr;
	logic [15:0] smp_val, main_amp, weld_amp, valve_mv;
	logic [31:0] wdata, rdata, r;
	logic [47:0] smp_data;
	logic [6:0]  fbus_force, ev;
	logic [2:0]  insp_fault;
	int          error_cnt, total_checks;

	wstm_top #(.TICK_CYC(10)) dut_u (.core_clk, .srst, .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_rq), .main_end, .main_amp,
		.cur_on, .start_in, .fault_ack, .calc_busy, .smp_valid, .smp_data, .gun_close, .weld_on,
		.weld_amp, .end_of_seq, .start_interlock, .next_squeeze, .series_end,
		.fault_acknowledge_message(fault_msg), .meas_open, .meas_empty, .valve_mv, .fbus_force,
		.insp_fault);
	wstm_src src_u (.core_clk, .srst, .go, .cur_len(8'h14), .smp_val, .main_end, .main_amp, .cur_on,
		.smp_valid, .smp_data);

	// Events the bench can wait on
	assign ev = {~gun_close, meas_empty, weld_on, series_end, next_squeeze, fault_msg, end_of_seq};

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic results;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait on one event bit; a timeout ends the run
	task automatic wt(input int s);
		int n;
		for (n = 0; n < 2000; n++) begin
			@(posedge core_clk);
			if (ev[s] === 1'b1) break;
		end
		if (n == 2000) begin
			error_cnt++;
			$display("[FAIL] %0t wait %0d timed out", $time, s);
			results();
		end
	endtask : wt

	// Request held until waitrequest is seen low, then released
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (wait_rq === 1'b0) break;
		end
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge core_clk);
		if (n == 20) begin
			error_cnt++;
			$display("[FAIL] %0t bus timed out", $time);
			results();
		end
	endtask : bus

	task automatic weld;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
	endtask : weld

	initial begin
		{srst, rd, wr, addr, wdata, go, start_in, fault_ack, calc_busy} = '0;
		srst = 1'b1;
		smp_val = 16'h0064;
		error_cnt = 0;
		total_checks = 0;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, 8'h00, 32'h0); chk(r, 32'h0);
		bus(1'b0, 8'h3C, 32'h0); chk(r, 32'h0);
		bus(1'b1, 8'h18, 32'h01);
		bus(1'b1, 8'h18, 32'h0F);
		bus(1'b0, 8'h18, 32'h0); chk(r, 32'h01);
		bus(1'b1, 8'h20, 32'h063);
		bus(1'b1, 8'h20, 32'h132);
		repeat (3) @(posedge core_clk);
		chk(valve_mv, 16'h26E8); chk(fbus_force, 7'h63);
		bus(1'b1, 8'h1C, 32'h1);
		repeat (3) @(posedge core_clk);
		chk(valve_mv, 16'h13A6); chk(fbus_force, 7'h32);
		bus(1'b1, 8'h04, 32'h0001_0001);
		bus(1'b1, 8'h08, 32'h0002_0002);
		bus(1'b1, 8'h10, 32'h0123);
		bus(1'b1, 8'h40, 32'h0064);
		// Good weld with the calculation still running past the hold time
		calc_busy <= 1'b1;
		weld();
		wt(4); chk(weld_amp, 16'h0123);
		repeat (100) @(posedge core_clk);
		chk({start_interlock, gun_close, end_of_seq}, 3'b110);
		calc_busy <= 1'b0;
		wt(0); chk({gun_close, start_interlock, insp_fault}, 5'h0);
		// Out-of-tolerance samples hold the gun until acknowledged
		smp_val <= 16'h00C8;
		weld();
		wt(1); chk({gun_close, insp_fault}, 4'h9);
		fault_ack <= 1'b1;
		wt(0); chk(gun_close, 1'b0);
		fault_ack <= 1'b0;
		// Start delay longer than the current time
		smp_val <= 16'h0064;
		bus(1'b1, 8'h14, 32'h5);
		weld();
		wt(5); chk(insp_fault, 3'h0);
		wt(0);
		// Series spot: open, squeeze, then start withdrawn in open time
		bus(1'b1, 8'h14, 32'h0);
		bus(1'b1, 8'h00, 32'h1);
		// Decrease of 1 ms, so the first current phase starts at main current
		bus(1'b1, 8'h0C, 32'h0100_0001);
		start_in <= 1'b1;
		weld();
		wt(4);
		chk(weld_amp, 16'h0800);
		wt(2); chk(gun_close, 1'b1);
		weld();
		wt(6);
		start_in <= 1'b0;
		wt(3); chk({gun_close, start_interlock}, 2'b00);
		results();
	end
endmodule : tb_top
`default_nettype wire
